/* adc_port_defines.vh */
// Functional notes
// R1: High select gives four top bits
// R2: Lines 0-3 carry bits 0-3 or 8-11
// R3: Completion flag low when result valid
// R4: Read on strobe fall with select low
// R5: Write rise captures byte, starts acquisition
// R6: External mode write rise starts conversion
// R7: Host supplies conversion clock in external mode
// R8: Data lines released when chip unselected
// R9: Flag returns high on read or write
// R10: Conversion takes thirteen clock cycles
// R11: Mode bit picks self-timed or held acquisition
// R12: New control byte aborts running conversion
// R13: Result held until next conversion completes
`ifndef ADC_PORT_DEFINES_VH
`define ADC_PORT_DEFINES_VH
`define ACQ_MODE_BIT 5
`define ACQ_CYCLES 4'h3
`define CONV_CYCLES 4'hd
`define CLK_DIV_DEFAULT 8'h1a
`define ST_IDLE 2'h0
`define ST_ACQ_TIMED 2'h1
`define ST_ACQ_HELD 2'h2
`define ST_CONV 2'h3
`endif

/* conv_clock_gen.v */
`timescale 1ns/1ps
`default_nettype none
module conv_clock_gen #(
    parameter DIV = 26
)(
    // Clock and reset
    input wire ref_clk,
    input wire reset,
    // Clock choice
    input wire ext_clk_mode,
    input wire ext_clk,
    // Enable out
    output reg tick
);
    reg [7:0] cnt_r;
    reg ext_d_r;

    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_r <= 8'h00;
            ext_d_r <= 1'b0;
            tick <= 1'b0;
        end
        else
        begin
            ext_d_r <= ext_clk;
            if (cnt_r == DIV[7:0] - 8'h01)
                cnt_r <= 8'h00;
            else
                cnt_r <= cnt_r + 8'h01;
            // R7: host clock falling edge
            if (ext_clk_mode)
                tick <= ext_d_r & ~ext_clk;
            else
                tick <= (cnt_r == 8'h00);
        end
    end
endmodule
`default_nettype wire

/* adc_parallel_host_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_defines.vh"
module adc_parallel_host_port #(
    parameter CLK_DIV = `CLK_DIV_DEFAULT
)(
    // Clock and reset
    input wire ref_clk,
    input wire reset,
    // Host strobes
    input wire cs_n,
    input wire rd_n,
    input wire wr_n,
    input wire high_byte_select,
    // Data bus
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe,
    // Conversion clock
    input wire ext_clk_mode,
    input wire ext_clk,
    // Converter core
    input wire [11:0] sample_value,
    output reg [7:0] control_byte,
    output reg converting,
    output reg done_n
);
    reg rd_d_r;
    reg wr_d_r;
    reg [1:0] state_r;
    reg [3:0] cnt_r;
    reg [11:0] result_r;
    wire tick;
    wire rd_fall = ~cs_n & rd_d_r & ~rd_n;
    wire wr_rise = ~cs_n & ~wr_d_r & wr_n;
    wire mode_held = data_in[`ACQ_MODE_BIT];

    conv_clock_gen #(.DIV(CLK_DIV)) u_clk (
        .ref_clk(ref_clk),
        .reset(reset),
        .ext_clk_mode(ext_clk_mode),
        .ext_clk(ext_clk),
        .tick(tick)
    );

    // Next values of every register but the strobe history, worked out in three blocks below
    reg [1:0] state_nxt;
    reg [3:0] cnt_nxt;
    reg [11:0] result_nxt;
    reg [7:0] control_byte_nxt;
    reg converting_nxt;
    reg done_n_nxt;
    reg [7:0] data_out_nxt;
    reg data_oe_nxt;
    wire acq_last = (cnt_r == `ACQ_CYCLES - 4'h1);
    wire conv_last = (cnt_r == `CONV_CYCLES - 4'h1);

    // R8: drive only while selected
    // Enable lags the pins by one cycle; the host holds its strobes longer
    always @*
    begin
        data_oe_nxt = ~cs_n & ~rd_n;
    end

    // R1: byte chosen by select pin
    // R2: low lines carry bits 8-11 when high
    always @*
    begin
        if (high_byte_select)
        begin
            data_out_nxt = {4'h0, result_r[11:8]};
        end
        else
        begin
            data_out_nxt = result_r[7:0];
        end
    end

    // Sequencer: a write always outranks a tick or a read in the same cycle
    always @*
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        result_nxt = result_r;
        control_byte_nxt = control_byte;
        converting_nxt = converting;
        done_n_nxt = done_n;
        if (wr_rise)
        begin
            // R5: capture byte on write rise
            control_byte_nxt = data_in;
            cnt_nxt = 4'h0;
            // R9: flag clears on new byte
            done_n_nxt = 1'b1;
            // R6: held acquisition ends on this write
            if (state_r == `ST_ACQ_HELD && !mode_held)
            begin
                state_nxt = `ST_CONV;
                converting_nxt = 1'b1;
            end
            else
            begin
                // R11: mode bit picks acquisition kind
                // R12: write aborts any conversion
                if (mode_held)
                begin
                    state_nxt = `ST_ACQ_HELD;
                end
                else
                begin
                    state_nxt = `ST_ACQ_TIMED;
                end
                converting_nxt = 1'b0;
            end
        end
        else
        begin
            // R4: read on strobe fall
            // R9: first read clears flag
            if (rd_fall)
            begin
                done_n_nxt = 1'b1;
            end
            case (state_r)
                `ST_IDLE:
                begin
                    cnt_nxt = 4'h0;
                end
                `ST_ACQ_TIMED:
                begin
                    // R11: three-cycle timed acquisition
                    if (tick)
                    begin
                        if (acq_last)
                        begin
                            cnt_nxt = 4'h0;
                            state_nxt = `ST_CONV;
                            converting_nxt = 1'b1;
                        end
                        else
                        begin
                            cnt_nxt = cnt_r + 4'h1;
                        end
                    end
                end
                `ST_ACQ_HELD:
                begin
                    // Held until the host writes again
                    cnt_nxt = 4'h0;
                end
                `ST_CONV:
                begin
                    // R10: thirteen conversion cycles
                    if (tick)
                    begin
                        if (conv_last)
                        begin
                            cnt_nxt = 4'h0;
                            state_nxt = `ST_IDLE;
                            converting_nxt = 1'b0;
                            // R13: result held until next done
                            result_nxt = sample_value;
                            // R3: flag low when result valid
                            // Completion wins over a read falling in the same cycle
                            done_n_nxt = 1'b0;
                        end
                        else
                        begin
                            cnt_nxt = cnt_r + 4'h1;
                        end
                    end
                end
                default:
                begin
                    state_nxt = `ST_IDLE;
                end
            endcase
        end
    end

    // Strobe history starts high so reset release gives no false write rise
    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            rd_d_r <= 1'b1;
            wr_d_r <= 1'b1;
            state_r <= `ST_IDLE;
            cnt_r <= 4'h0;
            result_r <= 12'h000;
            control_byte <= 8'h00;
            converting <= 1'b0;
            done_n <= 1'b1;
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end
        else
        begin
            rd_d_r <= rd_n;
            wr_d_r <= wr_n;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            result_r <= result_nxt;
            control_byte <= control_byte_nxt;
            converting <= converting_nxt;
            done_n <= done_n_nxt;
            data_out <= data_out_nxt;
            data_oe <= data_oe_nxt;
        end
    end
endmodule
`default_nettype wire

/* port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module port_sva (
    // Clock, strobes and outputs
    input wire ref_clk, reset, cs_n, rd_n, wr_n, high_byte_select, data_oe, converting, done_n,
    input wire [7:0] data_in, data_out, control_byte
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    sequence wr_take;
        !cs_n && wr_n && !$past(wr_n);
    endsequence
    sequence rd_take;
        !cs_n && !rd_n && $past(rd_n);
    endsequence
    oe_off_a: assert property (cs_n |=> !data_oe) else $error("bus driven unselected");
    oe_read_a: assert property (!cs_n && !rd_n |=> data_oe) else $error("bus idle in read");
    hi_zero_a: assert property (data_oe && $past(high_byte_select) |-> data_out[7:4] == 4'h0)
        else $error("top bits set");
    flag_read_a: assert property (rd_take |=> done_n) else $error("flag kept on read");
    flag_write_a: assert property (wr_take |=> done_n) else $error("flag kept on write");
    flag_src_a: assert property ($fell(done_n) |-> $past(converting)) else $error("flag without end");
    byte_cap_a: assert property (wr_take |=> control_byte == $past(data_in)) else $error("byte lost");
    held_acq_a: assert property (control_byte[5] ##1 control_byte[5] |-> !converting)
        else $error("held mode converts");
endmodule
`default_nettype wire

/* host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic ref_clk, ext_run, data_oe,
    input wire logic [7:0] data_out,
    output logic cs_n, rd_n, wr_n, high_byte_select, ext_clk = 1'b0,
    output logic [7:0] data_in
);
    // Idle bus levels before the first transfer
    initial
    begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        high_byte_select = 1'b0;
        data_in = 8'h00;
    end
    always @(posedge ref_clk)
        ext_clk <= ext_run & ~ext_clk;
    task automatic wr(input logic [7:0] b);
        @(posedge ref_clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        data_in <= b;
        @(posedge ref_clk) wr_n <= 1'b1;
        @(posedge ref_clk) cs_n <= 1'b1;
        // Inverted idle byte so a stale value cannot pass
        data_in <= ~b;
    endtask
    task automatic rd(input logic hb, output logic [7:0] v);
        @(posedge ref_clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        high_byte_select <= hb;
        repeat (2) @(posedge ref_clk);
        // Taken at the edge: the byte set up one edge earlier still stands
        v = data_oe ? data_out : 8'hxx;
        rd_n <= 1'b1;
        cs_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0, reset = 1'b1, ext_clk_mode = 1'b0, ext_run = 1'b0;
    logic [11:0] sample_value = 12'ha5c;
    wire cs_n, rd_n, wr_n, hbs, ext_clk, data_oe, converting, done_n;
    wire [7:0] data_in, data_out, control_byte;
    logic [7:0] v;
    int n, error_cnt = 0, checks = 0;
    host_model host (.ref_clk(ref_clk), .ext_run(ext_run), .data_oe(data_oe), .data_out(data_out), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .high_byte_select(hbs), .ext_clk(ext_clk), .data_in(data_in));
    adc_parallel_host_port #(.CLK_DIV(2)) dut (.ref_clk(ref_clk), .reset(reset), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .high_byte_select(hbs), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .ext_clk_mode(ext_clk_mode), .ext_clk(ext_clk), .sample_value(sample_value),
        .control_byte(control_byte), .converting(converting), .done_n(done_n));
    initial forever #4 ref_clk = ~ref_clk;
    task automatic check(input string what, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_conv;
        // A write that starts conversion at once raises it in this cycle
        #1 n = converting;
        for (int i = 0; i < 100 && done_n !== 1'b0; i++)
        begin
            @(posedge ref_clk);
            #1 n += converting;
        end
        check("flag low", done_n, 1'b0);
        check("conv len", n, 16'd26);
    endtask
    task automatic t_internal;
        host.wr(8'h00);
        wait_conv;
        host.rd(1'b0, v);
        check("low byte", v, 8'h5c);
        check("flag", done_n, 1'b1);
        sample_value <= 12'h3f1;
        host.rd(1'b1, v);
        check("high byte", v, 8'h0a);
        @(posedge ref_clk) #1 check("released", data_oe, 1'b0);
    endtask
    task automatic t_abort;
        host.wr(8'h00);
        repeat (12) @(posedge ref_clk);
        #1 check("busy", converting, 1'b1);
        host.wr(8'h00);
        #1 check("abort", converting, 1'b0);
        wait_conv;
    endtask
    task automatic t_external;
        ext_clk_mode <= 1'b1;
        ext_run <= 1'b1;
        host.wr(8'h20);
        repeat (40) @(posedge ref_clk);
        #1 check("held", converting, 1'b0);
        host.wr(8'h00);
        wait_conv;
        host.rd(1'b0, v);
        check("low byte", v, 8'hf1);
    endtask
    initial
    begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_internal;
        t_abort;
        t_external;
        stop_test;
    end
    initial
    begin
        #20000;
        error_cnt++;
        stop_test;
    end
endmodule
bind adc_parallel_host_port port_sva chk (.ref_clk(ref_clk), .reset(reset), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .high_byte_select(high_byte_select), .data_oe(data_oe), .converting(converting),
    .done_n(done_n), .data_in(data_in), .data_out(data_out), .control_byte(control_byte));
`default_nettype wire
